/* File: design/dpg_pkg.sv */
// Purpose: Shared constants and types for the dual GPIO port block
// Assumes: Byte-wide register port, one clock, synchronous reset
// Notes:   Register offsets are byte addresses on the plain register port
package dpg_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_FIRST_PORT_DATA       = 8'h05;
    localparam logic [7:0] OFS_SECOND_PORT_DATA      = 8'h06;
    localparam logic [7:0] OFS_OPTION_CONTROL        = 8'h81;
    localparam logic [7:0] OFS_FIRST_PORT_DIRECTION  = 8'h85;
    localparam logic [7:0] OFS_SECOND_PORT_DIRECTION = 8'h86;
    localparam logic [7:0] OFS_ANALOG_PIN_CONFIG     = 8'h9F;
    localparam logic [7:0] OFS_INTERRUPT_CONTROL     = 8'hA0;
    // Bit set registers: result = pins OR write data, stored in the latch
    localparam logic [7:0] OFS_FIRST_PORT_SET        = 8'hA1;
    localparam logic [7:0] OFS_SECOND_PORT_SET       = 8'hA2;
    // Bit clear registers: result = pins AND NOT write data
    localparam logic [7:0] OFS_FIRST_PORT_CLEAR      = 8'hA3;
    localparam logic [7:0] OFS_SECOND_PORT_CLEAR     = 8'hA4;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_OPTION_CONTROL        = 8'hFF;
    localparam logic [7:0] RST_FIRST_PORT_DIRECTION  = 8'h3F;
    localparam logic [7:0] RST_SECOND_PORT_DIRECTION = 8'hFF;
    localparam logic [2:0] RST_ANALOG_PIN_CONFIG     = 3'h0;
    localparam logic [7:0] RST_LATCH                 = 8'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int POS_PULLUP_ENABLE_N   = 7;
    localparam int POS_PORT_CHANGE_FLAG  = 0;
    localparam int POS_CHANGE_ENABLE     = 3;
    localparam int POS_OPEN_DRAIN_PIN    = 4;
    localparam int POS_EXT_INT           = 0;
    localparam int POS_PROG_CLK          = 6;
    localparam int POS_PROG_DATA         = 7;
    localparam int CHANGE_LO             = 4;
    localparam int CHANGE_HI             = 7;

    // ---------------------------------------------------------------
    // Analog select decode
    // ---------------------------------------------------------------
    localparam logic [2:0] CFG_ALL_ANALOG     = 3'h0;
    localparam logic [2:0] CFG_DIGITAL_MIN    = 3'h6;
    localparam logic [5:0] MASK_ALL_ANALOG    = 6'h2F;
    localparam logic [5:0] MASK_PART_ANALOG   = 6'h0B;
    localparam logic [5:0] MASK_NONE          = 6'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } dpg_req_t;

endpackage : dpg_pkg

/* File: design/dpg_gpio.sv */
// Purpose: Two general purpose ports, a 6-bit and an 8-bit, with pin sharing
// Assumes: Pin inputs synchronous to mclk_i; software keeps analog pins as inputs
// Notes:   Pads are split into in, out and output enable; board resolves levels
//
// Behaviour
// - First port: six pins, direction, latch, readback
// - Direction one tristates, zero drives latch
// - Reset: first port inputs, all but bit four read zero
// - Read returns pins, write loads latch
// - Set and clear writes are read-modify-write into latch
// - Bit four open drain, feeds timer clock
// - Analog select field; analog pins read zero
// - Upper two first-port bits read zero
// - Programming mode takes second port bits six, seven
// - Second port: eight pins, same direction encoding
// - Pull-ups on when option bit seven clear
// - Output pins never get pull-up
// - Pull-ups off after reset
// - Only input pins of upper four compared
// - Mismatch versus snapshot from last second port access sets change flag
// - Pending change can wake from sleep
// - Mismatch keeps setting flag; access ends it
// - Bit zero interrupt; bits six, seven programming
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps

module dpg_gpio #(
    parameter int PA_W = 6,
    parameter int PB_W = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire dpg_pkg::dpg_req_t req_i,
    output logic [7:0]            rdata_o,
    input  wire logic [PA_W-1:0]  pa_in_i,
    output logic [PA_W-1:0]       pa_out_o,
    output logic [PA_W-1:0]       pa_oe_o,
    input  wire logic [PB_W-1:0]  pb_in_i,
    output logic [PB_W-1:0]       pb_out_o,
    output logic [PB_W-1:0]       pb_oe_o,
    output logic [PB_W-1:0]       pb_pullup_o,
    input  wire logic             prog_mode_i,
    output logic                  timer_zero_clock_in_o,
    output logic                  ext_int_o,
    output logic                  prog_clk_o,
    output logic                  prog_data_o,
    output logic [PA_W-1:0]       analog_sel_o,
    output logic                  port_change_flag_o,
    output logic                  wake_o
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    localparam int CHANGE_HI_W = dpg_pkg::CHANGE_HI - dpg_pkg::CHANGE_LO + 1;

    logic [PA_W-1:0] pa_latch_q;
    logic [PA_W-1:0] pa_dir_q;
    logic [PB_W-1:0] pb_latch_q;
    logic [PB_W-1:0] pb_dir_q;
    logic [7:0]      option_q;
    logic [2:0]      acfg_q;
    logic            change_en_q;
    logic            flag_q;
    logic [CHANGE_HI_W-1:0] snap_q;

    logic [PA_W-1:0] analog_mask;
    logic [PA_W-1:0] pa_read;
    logic [PB_W-1:0] pb_read;
    logic [CHANGE_HI_W-1:0] mismatch;
    logic            pb_access;
    logic [7:0]      rdata_d;

    // ---------------------------------------------------------------
    // Decode and read paths
    // ---------------------------------------------------------------
    always_comb begin
        if (acfg_q == dpg_pkg::CFG_ALL_ANALOG) begin
            analog_mask = dpg_pkg::MASK_ALL_ANALOG[PA_W-1:0];
        end else if (acfg_q >= dpg_pkg::CFG_DIGITAL_MIN) begin
            analog_mask = dpg_pkg::MASK_NONE[PA_W-1:0];
        end else begin
            analog_mask = dpg_pkg::MASK_PART_ANALOG[PA_W-1:0];
        end
    end

    assign pa_read = pa_in_i & ~analog_mask;
    assign pb_read = pb_in_i;

    // Output pins drop out of the comparison entirely
    assign mismatch = (pb_in_i[dpg_pkg::CHANGE_HI:dpg_pkg::CHANGE_LO] ^ snap_q)
                    & pb_dir_q[dpg_pkg::CHANGE_HI:dpg_pkg::CHANGE_LO];

    assign pb_access = (req_i.we || req_i.re) &&
                       (req_i.addr == dpg_pkg::OFS_SECOND_PORT_DATA ||
                        req_i.addr == dpg_pkg::OFS_SECOND_PORT_SET ||
                        req_i.addr == dpg_pkg::OFS_SECOND_PORT_CLEAR);

    always_comb begin
        rdata_d = 8'h00;
        if (req_i.re) begin
            case (req_i.addr)
                dpg_pkg::OFS_FIRST_PORT_DATA:       rdata_d = 8'(pa_read);
                dpg_pkg::OFS_SECOND_PORT_DATA:      rdata_d = 8'(pb_read);
                dpg_pkg::OFS_OPTION_CONTROL:        rdata_d = option_q;
                dpg_pkg::OFS_FIRST_PORT_DIRECTION:  rdata_d = 8'(pa_dir_q);
                dpg_pkg::OFS_SECOND_PORT_DIRECTION: rdata_d = 8'(pb_dir_q);
                dpg_pkg::OFS_ANALOG_PIN_CONFIG:     rdata_d = 8'(acfg_q);
                dpg_pkg::OFS_INTERRUPT_CONTROL: begin
                    rdata_d[dpg_pkg::POS_PORT_CHANGE_FLAG] = flag_q;
                    rdata_d[dpg_pkg::POS_CHANGE_ENABLE]    = change_en_q;
                end
                default:                            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Output latches
    // ---------------------------------------------------------------
    // Latch takes every data, set or clear write whatever the direction bits say
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pa_latch_q <= dpg_pkg::RST_LATCH[PA_W-1:0];
        end else if (req_i.we) begin
            case (req_i.addr)
                dpg_pkg::OFS_FIRST_PORT_DATA:  pa_latch_q <= req_i.wdata[PA_W-1:0];
                dpg_pkg::OFS_FIRST_PORT_SET:   pa_latch_q <= pa_in_i | req_i.wdata[PA_W-1:0];
                dpg_pkg::OFS_FIRST_PORT_CLEAR: pa_latch_q <= pa_in_i & ~req_i.wdata[PA_W-1:0];
                default:                       pa_latch_q <= pa_latch_q;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pb_latch_q <= dpg_pkg::RST_LATCH[PB_W-1:0];
        end else if (req_i.we) begin
            case (req_i.addr)
                dpg_pkg::OFS_SECOND_PORT_DATA:  pb_latch_q <= req_i.wdata[PB_W-1:0];
                dpg_pkg::OFS_SECOND_PORT_SET:   pb_latch_q <= pb_in_i | req_i.wdata[PB_W-1:0];
                dpg_pkg::OFS_SECOND_PORT_CLEAR: pb_latch_q <= pb_in_i & ~req_i.wdata[PB_W-1:0];
                default:                        pb_latch_q <= pb_latch_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pa_dir_q <= dpg_pkg::RST_FIRST_PORT_DIRECTION[PA_W-1:0];
            pb_dir_q <= dpg_pkg::RST_SECOND_PORT_DIRECTION[PB_W-1:0];
            option_q <= dpg_pkg::RST_OPTION_CONTROL;
            acfg_q   <= dpg_pkg::RST_ANALOG_PIN_CONFIG;
        end else if (req_i.we) begin
            case (req_i.addr)
                dpg_pkg::OFS_FIRST_PORT_DIRECTION:  pa_dir_q <= req_i.wdata[PA_W-1:0];
                dpg_pkg::OFS_SECOND_PORT_DIRECTION: pb_dir_q <= req_i.wdata[PB_W-1:0];
                dpg_pkg::OFS_OPTION_CONTROL:        option_q <= req_i.wdata;
                dpg_pkg::OFS_ANALOG_PIN_CONFIG:     acfg_q   <= req_i.wdata[2:0];
                default:                            acfg_q   <= acfg_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Change detection
    // ---------------------------------------------------------------
    // Any second port data, set or clear access re-arms the snapshot, so polling ends the mismatch
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            snap_q <= '0;
        end else if (pb_access) begin
            snap_q <= pb_in_i[dpg_pkg::CHANGE_HI:dpg_pkg::CHANGE_LO];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            change_en_q <= 1'b0;
        end else if (req_i.we && req_i.addr == dpg_pkg::OFS_INTERRUPT_CONTROL) begin
            change_en_q <= req_i.wdata[dpg_pkg::POS_CHANGE_ENABLE];
        end
    end

    // Set beats a same-cycle software clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (|mismatch) begin
            flag_q <= 1'b1;
        end else if (req_i.we && req_i.addr == dpg_pkg::OFS_INTERRUPT_CONTROL) begin
            flag_q <= req_i.wdata[dpg_pkg::POS_PORT_CHANGE_FLAG];
        end
    end

    // ---------------------------------------------------------------
    // Pad drive, registered
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PA_W; gi++) begin : g_pa
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    pa_out_o[gi] <= 1'b0;
                    pa_oe_o[gi]  <= 1'b0;
                end else if (gi == dpg_pkg::POS_OPEN_DRAIN_PIN) begin
                    // Can only sink: drive low while latch is zero
                    pa_out_o[gi] <= 1'b0;
                    pa_oe_o[gi]  <= ~pa_dir_q[gi] & ~pa_latch_q[gi];
                end else begin
                    // Analog pins still obey direction; software keeps them inputs
                    pa_out_o[gi] <= pa_latch_q[gi];
                    pa_oe_o[gi]  <= ~pa_dir_q[gi];
                end
            end
        end
        for (gi = 0; gi < PB_W; gi++) begin : g_pb
            localparam bit SHARED = (gi == dpg_pkg::POS_PROG_CLK) || (gi == dpg_pkg::POS_PROG_DATA);
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    pb_out_o[gi]    <= 1'b0;
                    pb_oe_o[gi]     <= 1'b0;
                    pb_pullup_o[gi] <= 1'b0;
                end else begin
                    pb_out_o[gi]    <= pb_latch_q[gi];
                    pb_oe_o[gi]     <= ~pb_dir_q[gi] & ~(SHARED & prog_mode_i);
                    pb_pullup_o[gi] <= ~option_q[dpg_pkg::POS_PULLUP_ENABLE_N] & pb_dir_q[gi];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Shared functions and status outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            timer_zero_clock_in_o <= 1'b0;
            ext_int_o             <= 1'b0;
            prog_clk_o            <= 1'b0;
            prog_data_o           <= 1'b0;
            analog_sel_o          <= '0;
            port_change_flag_o    <= 1'b0;
            wake_o                <= 1'b0;
        end else begin
            timer_zero_clock_in_o <= pa_in_i[dpg_pkg::POS_OPEN_DRAIN_PIN];
            ext_int_o             <= pb_in_i[dpg_pkg::POS_EXT_INT];
            prog_clk_o            <= prog_mode_i & pb_in_i[dpg_pkg::POS_PROG_CLK];
            prog_data_o           <= prog_mode_i & pb_in_i[dpg_pkg::POS_PROG_DATA];
            analog_sel_o          <= analog_mask;
            port_change_flag_o    <= flag_q;
            wake_o                <= flag_q & change_en_q;
        end
    end

endmodule : dpg_gpio

/* File: tb/dpg_gpio_asserts.sv */
// Purpose: Port-level checks for the dual GPIO block
// Assumes: One clock domain, bound to every dpg_gpio
// Notes:   Outputs lag their registers by one cycle
`timescale 1ns/100ps
module dpg_gpio_asserts #(
    parameter int PA_W = 6,
    parameter int PB_W = 8
) (
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    input wire dpg_pkg::dpg_req_t req_i,
    input wire logic [7:0]        rdata_o,
    input wire logic [PA_W-1:0]   pa_in_i,
    input wire logic [PA_W-1:0]   pa_out_o,
    input wire logic [PA_W-1:0]   pa_oe_o,
    input wire logic [PB_W-1:0]   pb_in_i,
    input wire logic [PB_W-1:0]   pb_out_o,
    input wire logic [PB_W-1:0]   pb_oe_o,
    input wire logic [PB_W-1:0]   pb_pullup_o,
    input wire logic              prog_mode_i,
    input wire logic              timer_zero_clock_in_o,
    input wire logic              ext_int_o,
    input wire logic              prog_clk_o,
    input wire logic              prog_data_o,
    input wire logic [PA_W-1:0]   analog_sel_o,
    input wire logic              port_change_flag_o,
    input wire logic              wake_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Lone write, so no later write hides the result
    sequence s_dir_wr;
        req_i.we && req_i.addr == dpg_pkg::OFS_FIRST_PORT_DIRECTION ##1 !req_i.we;
    endsequence
    sequence s_latch_wr;
        req_i.we && req_i.addr == dpg_pkg::OFS_SECOND_PORT_DATA ##1 !req_i.we;
    endsequence
    a_read_idle: assert property (!$past(req_i.re) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_high_bits_zero: assert property ($past(req_i.re) && $past(req_i.addr[6:0]) == 7'h05
        |-> rdata_o[7:6] == 2'h0) else $error("unimplemented bits read high");
    a_open_drain: assert property (pa_out_o[4] == 1'b0) else $error("open drain pin driven high");
    a_pullup_output: assert property ((pb_pullup_o & pb_oe_o) == 8'h00)
        else $error("pull-up on driven pin");
    a_prog_owns_pins: assert property (prog_mode_i ##1 prog_mode_i |-> pb_oe_o[7:6] == 2'h0)
        else $error("port drives programming pins");
    a_prog_gated: assert property (!$past(prog_mode_i) |-> !prog_clk_o && !prog_data_o)
        else $error("programming lines active");
    a_shared_inputs: assert property ($past(rst_n_i) |-> ext_int_o == $past(pb_in_i[0])
        && timer_zero_clock_in_o == $past(pa_in_i[4])) else $error("shared input copy wrong");
    a_wake_flag: assert property (wake_o |-> port_change_flag_o) else $error("wake without flag");
    a_dir_drive: assert property (s_dir_wr |-> ##1 pa_oe_o[3:0] == ~$past(req_i.wdata[3:0], 2))
        else $error("enable does not follow direction");
    a_latch_drive: assert property (s_latch_wr |-> ##1 pb_out_o == $past(req_i.wdata, 2))
        else $error("latch not driven");
    a_analog_zero: assert property ($past(req_i.re) && $past(req_i.addr) == dpg_pkg::OFS_FIRST_PORT_DATA
        |-> (rdata_o[5:0] & analog_sel_o) == 6'h00) else $error("analog pin reads high");
endmodule : dpg_gpio_asserts

bind dpg_gpio dpg_gpio_asserts #(.PA_W(PA_W), .PB_W(PB_W)) u_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .pa_in_i(pa_in_i), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o),
    .pb_in_i(pb_in_i), .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o),
    .prog_mode_i(prog_mode_i), .timer_zero_clock_in_o(timer_zero_clock_in_o), .ext_int_o(ext_int_o),
    .prog_clk_o(prog_clk_o), .prog_data_o(prog_data_o), .analog_sel_o(analog_sel_o),
    .port_change_flag_o(port_change_flag_o), .wake_o(wake_o));

/* File: tb/dpg_board.sv */
// Purpose: Board around the pads: drivers, pull-ups, floating nets
// Assumes: External drivers win over the port in contention
// Notes:   Floating nets toggle so stale values never read back
`timescale 1ns/100ps
module dpg_board (
    input  wire logic       mclk_i,
    input  wire logic [5:0] pa_out_i,
    input  wire logic [5:0] pa_oe_i,
    input  wire logic [5:0] ext_a_i,
    input  wire logic [5:0] ext_a_en_i,
    output logic      [5:0] pa_in_o,
    input  wire logic [7:0] pb_out_i,
    input  wire logic [7:0] pb_oe_i,
    input  wire logic [7:0] pb_pullup_i,
    input  wire logic [7:0] ext_b_i,
    input  wire logic [7:0] ext_b_en_i,
    output logic      [7:0] pb_in_o
);
    logic float_q = 1'b0;
    always @(posedge mclk_i) float_q <= ~float_q;
    // Open drain pin has a board pull-up resistor
    always_comb begin
        for (int i = 0; i < 6; i++)
            pa_in_o[i] = ext_a_en_i[i] ? ext_a_i[i] : pa_oe_i[i] ? pa_out_i[i] : (i == 4) | float_q;
        for (int i = 0; i < 8; i++)
            pb_in_o[i] = ext_b_en_i[i] ? ext_b_i[i] : pb_oe_i[i] ? pb_out_i[i] : pb_pullup_i[i] | float_q;
    end
endmodule : dpg_board

/* File: tb/dual_port_gpio_with_change_irq_tb_top.sv */
// Purpose: Register-level self-checking bench for the dual GPIO block
// Assumes: Board model resolves pads
// Notes:   Only driven or pulled pins are compared
`timescale 1ns/100ps
module dual_port_gpio_with_change_irq_tb_top;
    logic              mclk_i, rst_n_i, prog_mode_i, t0ck, eint, pclk, pdat, flag, wake;
    dpg_pkg::dpg_req_t req;
    logic [7:0]        rdata, pb_out, pb_oe, pb_pu, pb_in, ext_b, ext_b_en;
    logic [5:0]        pa_out, pa_oe, pa_in, ext_a, ext_a_en, an_sel;
    int                n_errors = 0;
    int                n_tests = 0;

    dpg_gpio dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata), .pa_in_i(pa_in),
        .pa_out_o(pa_out), .pa_oe_o(pa_oe), .pb_in_i(pb_in), .pb_out_o(pb_out), .pb_oe_o(pb_oe),
        .pb_pullup_o(pb_pu), .prog_mode_i(prog_mode_i), .timer_zero_clock_in_o(t0ck), .ext_int_o(eint),
        .prog_clk_o(pclk), .prog_data_o(pdat), .analog_sel_o(an_sel), .port_change_flag_o(flag), .wake_o(wake));
    dpg_board board (.mclk_i(mclk_i), .pa_out_i(pa_out), .pa_oe_i(pa_oe), .ext_a_i(ext_a), .ext_a_en_i(ext_a_en),
        .pa_in_o(pa_in), .pb_out_i(pb_out), .pb_oe_i(pb_oe), .pb_pullup_i(pb_pu), .ext_b_i(ext_b),
        .ext_b_en_i(ext_b_en), .pb_in_o(pb_in));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic end_of_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        req.addr  <= a;
        req.wdata <= d;
        req.we    <= 1'b1;
        @(posedge mclk_i);
        req.we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        req.addr <= a;
        req.re   <= 1'b1;
        @(posedge mclk_i);
        req.re   <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd

    // Waits four cycles, then checks wake and flag (select zero) or the pull-up outputs
    task automatic settle(input logic [7:0] got_sel, input logic [7:0] exp);
        repeat (4) @(posedge mclk_i);
        #1 chk(got_sel == 8'h00 ? {6'h00, wake, flag} : pb_pu, exp);
    endtask : settle

    initial begin
        req = '0;
        prog_mode_i = 1'b0;
        ext_a = 6'h2F;
        ext_a_en = 6'h3F;
        ext_b = 8'h00;
        ext_b_en = 8'h00;
        rst_n_i = 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1 chk(pb_pu, 8'h00);
        chk({2'h0, pa_oe}, 8'h00);
        rd(dpg_pkg::OFS_OPTION_CONTROL, 8'hFF);
        rd(dpg_pkg::OFS_FIRST_PORT_DIRECTION, 8'h3F);
        rd(dpg_pkg::OFS_SECOND_PORT_DIRECTION, 8'hFF);
        rd(dpg_pkg::OFS_FIRST_PORT_DATA, 8'h00);
        rd(8'h10, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(dpg_pkg::OFS_ANALOG_PIN_CONFIG, 8'(c));
            rd(dpg_pkg::OFS_FIRST_PORT_DATA, (c == 0) ? 8'h00 : (c < 6) ? 8'h24 : 8'h2F);
        end
        chk({2'h0, an_sel}, 8'h00);
        wr(dpg_pkg::OFS_FIRST_PORT_DATA, 8'h15);
        ext_a_en <= 6'h02;
        ext_a <= 6'h02;
        wr(dpg_pkg::OFS_FIRST_PORT_DIRECTION, 8'hC0);
        rd(dpg_pkg::OFS_FIRST_PORT_DIRECTION, 8'h00);
        wr(dpg_pkg::OFS_FIRST_PORT_SET, 8'h20);
        ext_a_en <= 6'h00;
        rd(dpg_pkg::OFS_FIRST_PORT_DATA, 8'h37);
        chk({2'h0, pa_oe}, 8'h2F);
        wr(dpg_pkg::OFS_FIRST_PORT_CLEAR, 8'h10);
        rd(dpg_pkg::OFS_FIRST_PORT_DATA, 8'h27);
        chk({2'h0, pa_oe}, 8'h3F);
        wr(dpg_pkg::OFS_SECOND_PORT_DATA, 8'hA5);
        wr(dpg_pkg::OFS_SECOND_PORT_DIRECTION, 8'h00);
        rd(dpg_pkg::OFS_SECOND_PORT_DATA, 8'hA5);
        wr(dpg_pkg::OFS_SECOND_PORT_SET, 8'h02);
        wr(dpg_pkg::OFS_SECOND_PORT_CLEAR, 8'h80);
        rd(dpg_pkg::OFS_SECOND_PORT_DATA, 8'h27);
        wr(dpg_pkg::OFS_OPTION_CONTROL, 8'h7F);
        wr(dpg_pkg::OFS_SECOND_PORT_DIRECTION, 8'hF0);
        settle(8'h01, 8'hF0);
        // This read arms the snapshot; the later second port read ends the mismatch
        rd(dpg_pkg::OFS_SECOND_PORT_DATA, 8'hF7);
        wr(dpg_pkg::OFS_INTERRUPT_CONTROL, 8'h08);
        ext_b_en <= 8'h20;
        settle(8'h00, 8'h03);
        wr(dpg_pkg::OFS_INTERRUPT_CONTROL, 8'h08);
        settle(8'h00, 8'h03);
        rd(dpg_pkg::OFS_SECOND_PORT_DATA, 8'hD7);
        wr(dpg_pkg::OFS_INTERRUPT_CONTROL, 8'h08);
        settle(8'h00, 8'h00);
        wr(dpg_pkg::OFS_SECOND_PORT_DIRECTION, 8'h70);
        settle(8'h00, 8'h00);
        ext_b_en <= 8'hC1;
        ext_b <= 8'h41;
        prog_mode_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk({pdat, pclk, eint, t0ck, pb_oe[7:6], 2'h0}, 8'h60);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        prog_mode_i <= 1'b0;
        rd(dpg_pkg::OFS_SECOND_PORT_DIRECTION, 8'hFF);
        chk(pb_pu, 8'h00);
        end_of_test();
    end

    initial begin
        repeat (2000) @(posedge mclk_i);
        n_errors++;
        end_of_test();
    end
endmodule : dual_port_gpio_with_change_irq_tb_top
